// ==== bench/tb.sv ====
// self-checking bench for the dual timer block, driven over its register bus and pins
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dual_timer_pkg::*;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] rw;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic pin_a = 1'b1;
  // external inputs rest at their inactive level for the active-low default
  logic irq_a = 1'b1;
  logic irq_b = 1'b1;
  logic ext_clk = 1'b0;
  logic [2:0] ack = 3'h0;
  logic [4:0] flg;
  int miscompares = 0;
  int tests_run = 0;

  always #5 clock_i = ~clock_i;

  dual_timer_split_mode_control dual_timer_split_mode_control_inst (
    .clock_i(clock_i), .srst_i(srst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .timer_a_count_pin_i(pin_a), .timer_b_count_pin_i(1'b1),
    .ext_irq_a_input_i(irq_a), .ext_irq_b_input_i(irq_b), .ext_clock_i(ext_clk),
    .timer_a_vector_ack_i(ack[0]), .timer_b_vector_ack_i(ack[1]),
    .ext_irq_a_vector_ack_i(ack[2]), .ext_irq_b_vector_ack_i(1'b0),
    .timer_a_overflow_flag_o(flg[0]), .timer_b_overflow_flag_o(flg[1]),
    .ext_irq_a_flag_o(flg[2]), .ext_irq_b_flag_o(flg[3]),
    .timer_b_overflow_pulse_o(flg[4])
  );

  function automatic logic [ADDR_W-1:0] addr(input logic [7:0] idx);
    return ADDR_W'({idx, 2'h0});
  endfunction

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic check_flag(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  // address and data are offered together and each is dropped once taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic at = 1'b0;
    logic wt = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(at && wt)) begin
      @(posedge clock_i);
      if (awvalid && awready) begin
        at = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wt = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clock_i); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
    // one idle edge so the next access never reassigns bready in this step
    @(posedge clock_i);
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock_i); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clock_i); while (!rvalid);
    rw = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic wait_bit(input int k, input int lim, input string what);
    logic seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++) begin
      @(posedge clock_i);
      seen = flg[k];
    end
    check_flag(what, 1'b1, seen);
  endtask

  // vector acknowledge, then look at the flag once the clearing edge has landed
  task automatic ack_pulse(input int k, input string what);
    ack[k] <= 1'b1;
    @(posedge clock_i);
    ack[k] <= 1'b0;
    @(posedge clock_i);
    check_flag(what, 1'b0, flg[k]);
  endtask

  task automatic t_reset;
    rd_reg(addr(IDX_RUN_FLAGS));
    check_word("run flags reset", 32'h0, rw);
    check_word("read resp", 32'(RESP_OKAY), 32'(resp));
    rd_reg(addr(IDX_MODE));
    check_word("mode reset", 32'h0, rw);
    rd_reg(addr(8'h90));
    check_word("unmapped read data", 32'h0, rw);
    check_word("unmapped read resp", 32'(RESP_SLVERR), 32'(resp));
    wr(addr(8'h90), 8'h55);
    check_word("unmapped write resp", 32'(RESP_SLVERR), 32'(resp));
    wr(addr(IDX_MODE) + 12'h001, 8'h55);
    check_word("unaligned write resp", 32'(RESP_SLVERR), 32'(resp));
    rd_reg(addr(IDX_MODE));
    check_word("mode after refused write", 32'h0, rw);
    $display("test reset done");
  endtask

  task automatic t_split;
    wr(addr(IDX_CLK_CTRL), 8'h18);
    wr(addr(IDX_A_HIGH), 8'hfe);
    wr(addr(IDX_A_LOW), 8'h00);
    wr(addr(IDX_B_HIGH), 8'hff);
    wr(addr(IDX_B_LOW), 8'hfe);
    wr(addr(IDX_MODE), 8'h13);
    wait_bit(4, 20, "timer b pulse in split");
    check_flag("timer b flag from timer b", 1'b0, flg[1]);
    wr(addr(IDX_MODE), 8'h33);
    wr(addr(IDX_B_LOW), 8'hf0);
    idle(10);
    rd_reg(addr(IDX_B_LOW));
    check_word("timer b low in mode 3", 32'hf0, rw);
    rd_reg(addr(IDX_A_LOW));
    check_word("split low byte idle", 32'h0, rw);
    wr(addr(IDX_RUN_FLAGS), 8'h40);
    wait_bit(1, 20, "timer b flag from high byte");
    ack_pulse(1, "timer b flag after vector");
    wr(addr(IDX_RUN_FLAGS), 8'h00);
    $display("test split done");
  endtask

  task automatic t_wide;
    wr(addr(IDX_MODE), 8'h01);
    wr(addr(IDX_A_HIGH), 8'hff);
    wr(addr(IDX_A_LOW), 8'hfd);
    wr(addr(IDX_RUN_FLAGS), 8'h10);
    wait_bit(0, 20, "timer a flag 16-bit");
    ack_pulse(0, "timer a flag after vector");
    wr(addr(IDX_RUN_FLAGS), 8'h00);
    $display("test wide done");
  endtask

  task automatic t_thirteen;
    wr(addr(IDX_CLK_CTRL), 8'h01);
    wr(addr(IDX_MODE), 8'h00);
    wr(addr(IDX_A_HIGH), 8'hff);
    wr(addr(IDX_A_LOW), 8'h5e);
    wr(addr(IDX_RUN_FLAGS), 8'h10);
    // two ticks at divide by 4 fit in 11 cycles, at divide by 12 they cannot
    wait_bit(0, 11, "timer a flag 13-bit");
    wr(addr(IDX_RUN_FLAGS), 8'h00);
    check_flag("timer a flag software clear", 1'b0, flg[0]);
    rd_reg(addr(IDX_A_HIGH));
    check_word("13-bit high byte", 32'h0, rw);
    rd_reg(addr(IDX_A_LOW));
    check_word("13-bit upper low bits", 32'h40, rw & 32'he0);
    $display("test thirteen done");
  endtask

  task automatic t_pin;
    wr(addr(IDX_CLK_CTRL), 8'h18);
    wr(addr(IDX_MODE), 8'h06);
    wr(addr(IDX_A_HIGH), 8'h10);
    wr(addr(IDX_A_LOW), 8'hff);
    wr(addr(IDX_RUN_FLAGS), 8'h10);
    idle(10);
    check_flag("counter without pin fall", 1'b0, flg[0]);
    pin_a <= 1'b0;
    idle(4);
    pin_a <= 1'b1;
    wait_bit(0, 12, "timer a flag on pin fall");
    wr(addr(IDX_RUN_FLAGS), 8'h00);
    rd_reg(addr(IDX_A_LOW));
    check_word("reloaded low byte", 32'h10, rw);
    rd_reg(addr(IDX_A_HIGH));
    check_word("reload byte kept", 32'h10, rw);
    $display("test pin done");
  endtask

  task automatic t_gate;
    irq_a <= 1'b0;
    wr(addr(IDX_IRQ_CFG), 8'h08);
    wr(addr(IDX_MODE), 8'h09);
    wr(addr(IDX_A_LOW), 8'h00);
    wr(addr(IDX_A_HIGH), 8'h00);
    wr(addr(IDX_RUN_FLAGS), 8'h10);
    idle(10);
    rd_reg(addr(IDX_A_LOW));
    check_word("gated low byte", 32'h0, rw);
    irq_a <= 1'b1;
    idle(10);
    rd_reg(addr(IDX_A_LOW));
    check_flag("low byte counts with gate open", 1'b1, rw != 32'h0);
    wr(addr(IDX_RUN_FLAGS), 8'h00);
    $display("test gate done");
  endtask

  task automatic t_ext;
    irq_a <= 1'b0;
    idle(8);
    wr(addr(IDX_RUN_FLAGS), 8'h01);
    check_flag("ext a flag cleared", 1'b0, flg[2]);
    irq_a <= 1'b1;
    wait_bit(2, 12, "ext a flag on edge");
    ack_pulse(2, "ext a flag after vector");
    wr(addr(IDX_RUN_FLAGS), 8'h00);
    wait_bit(2, 8, "ext a flag on level");
    wr(addr(IDX_IRQ_CFG), 8'h00);
    wr(addr(IDX_RUN_FLAGS), 8'h00);
    idle(8);
    check_flag("ext a flag inverse polarity", 1'b0, flg[2]);
    irq_b <= 1'b0;
    wait_bit(3, 8, "ext b flag on level");
    irq_b <= 1'b1;
    $display("test ext done");
  endtask

  task automatic ext_rise;
    ext_clk <= 1'b1;
    idle(4);
    ext_clk <= 1'b0;
    idle(4);
  endtask

  // the prescaler count is unknown on entry, so the first tick needs up to 8 edges
  task automatic t_ext_clock;
    int n = 0;
    wr(addr(IDX_CLK_CTRL), 8'h03);
    wr(addr(IDX_MODE), 8'h01);
    wr(addr(IDX_A_HIGH), 8'hff);
    wr(addr(IDX_A_LOW), 8'hff);
    wr(addr(IDX_RUN_FLAGS), 8'h10);
    idle(20);
    check_flag("timer a still without ext clock", 1'b0, flg[0]);
    while (!flg[0] && n < 10) begin
      ext_rise();
      n++;
    end
    check_flag("timer a flag from ext clock", 1'b1, flg[0]);
    wr(addr(IDX_RUN_FLAGS), 8'h10);
    repeat (16) ext_rise();
    rd_reg(addr(IDX_A_LOW));
    check_word("ticks from 16 ext edges", 32'h2, rw);
    wr(addr(IDX_RUN_FLAGS), 8'h00);
    $display("test ext clock done");
  endtask

  task automatic final_report;
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    miscompares++;
    $display("watchdog expired");
    final_report;
  end

  initial begin
    repeat (5) @(posedge clock_i);
    srst_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    t_reset;
    t_split;
    t_wide;
    t_thirteen;
    t_pin;
    t_gate;
    t_ext;
    t_ext_clock;
    final_report;
  end
endmodule // tb

// ==== hw/dual_timer_pkg.sv ====
// constants, field positions and types shared by the dual timer block
package dual_timer_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned MODE_W = 2;
  localparam int unsigned PRE_W = 6;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_RUN_FLAGS = 8'h88;
  localparam logic [7:0] IDX_MODE = 8'h89;
  localparam logic [7:0] IDX_A_LOW = 8'h8a;
  localparam logic [7:0] IDX_B_LOW = 8'h8b;
  localparam logic [7:0] IDX_A_HIGH = 8'h8c;
  localparam logic [7:0] IDX_B_HIGH = 8'h8d;
  localparam logic [7:0] IDX_CLK_CTRL = 8'h8e;
  localparam logic [7:0] IDX_IRQ_CFG = 8'h8f;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // run and flag register
  localparam int B_TF1 = 7;
  localparam int B_TR1 = 6;
  localparam int B_TF0 = 5;
  localparam int B_TR0 = 4;
  localparam int B_IE1 = 3;
  localparam int B_IT1 = 2;
  localparam int B_IE0 = 1;
  localparam int B_IT0 = 0;
  // mode register
  localparam int M_TIMER_B_GATE = 7;
  localparam int M_CT1 = 6;
  localparam int M_B_MODE = 4;
  localparam int M_TIMER_A_GATE = 3;
  localparam int M_CT0 = 2;
  localparam int M_A_MODE = 0;
  // clock control and external input configuration
  localparam int C_T1_SYS = 4;
  localparam int C_T0_SYS = 3;
  localparam int C_SCA = 0;
  localparam logic [7:0] CLK_CTRL_MASK = 8'h1b;
  localparam int P_A_POL = 3;
  localparam int P_B_POL = 7;
  localparam logic [7:0] IRQ_CFG_MASK = 8'h88;
  localparam int unsigned LOW13_W = 5;
  localparam int unsigned DIV12 = 12;
  localparam int unsigned DIV4 = 4;
  localparam int unsigned DIV48 = 48;
  localparam int unsigned DIV_EXT = 8;
  // synchroniser pin slots
  localparam int unsigned NPINS = 5;
  localparam int PIN_T0 = 0;
  localparam int PIN_T1 = 1;
  localparam int PIN_EXT_IRQ_A_INPUT = 2;
  localparam int PIN_EXT_IRQ_B_INPUT = 3;
  localparam int PIN_EXTCLK = 4;
  localparam logic [2:0] SYNC_FILL = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [MODE_W-1:0] {MODE_13BIT, MODE_16BIT, MODE_RELOAD8, MODE_SPLIT} timer_mode_t;
  typedef enum logic [1:0] {PRE_DIV12, PRE_DIV4, PRE_DIV48, PRE_EXT8} prescale_t;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    return ADDR_W'({idx, 2'h0});
  endfunction
endpackage

// ==== hw/dual_timer_split_mode_control.sv ====
// two counter/timers with split mode, control registers and an AXI4-Lite slave
//
// Design decision made here: the AXI4-Lite register port.
module dual_timer_split_mode_control (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [dual_timer_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [dual_timer_pkg::DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [dual_timer_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [dual_timer_pkg::DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic timer_a_count_pin_i,
  input wire logic timer_b_count_pin_i,
  input wire logic ext_irq_a_input_i,
  input wire logic ext_irq_b_input_i,
  input wire logic ext_clock_i,
  input wire logic timer_a_vector_ack_i,
  input wire logic timer_b_vector_ack_i,
  input wire logic ext_irq_a_vector_ack_i,
  input wire logic ext_irq_b_vector_ack_i,
  output logic timer_a_overflow_flag_o,
  output logic timer_b_overflow_flag_o,
  output logic ext_irq_a_flag_o,
  output logic ext_irq_b_flag_o,
  output logic timer_b_overflow_pulse_o
);
  import dual_timer_pkg::*;

  // returns {overflow, high, low} after one increment
  function automatic logic [16:0] count_step(input timer_mode_t m, input logic [7:0] lo,
                                             input logic [7:0] hi);
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0] c8;
    c13 = {1'b0, hi, lo[LOW13_W-1:0]} + 14'h1;
    c16 = {1'b0, hi, lo} + 17'h1;
    c8 = {1'b0, lo} + 9'h1;
    case (m)
      MODE_13BIT: count_step = {c13[13], c13[12:LOW13_W], lo[7:LOW13_W], c13[LOW13_W-1:0]};
      MODE_16BIT: count_step = c16;
      MODE_RELOAD8: count_step = {c8[8], hi, c8[8] ? hi : c8[7:0]};
      default: count_step = {c8[8], hi, c8[7:0]};
    endcase
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a == byte_addr(idx);
  endfunction

  pin_sync_if #(.N(NPINS)) sync_if ();

  pin_sampler #(.N(NPINS)) u_sampler (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .pins_i({ext_clock_i, ext_irq_b_input_i, ext_irq_a_input_i,
             timer_b_count_pin_i, timer_a_count_pin_i}),
    .sync_o(sync_if)
  );

  logic [7:0] run_flags_q, mode_q, clk_ctrl_q, irq_cfg_q;
  logic [7:0] a_low_q, a_high_q, b_low_q, b_high_q;
  logic aw_full_q, w_full_q, bvalid_q, rvalid_q, b_pulse_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [DATA_W-1:0] rdata_q;
  logic do_write, wr_hit;
  logic [PRE_W-1:0] pre_cnt_q, pre_limit;
  logic pre_step, pre_tick, tick_a, tick_b, act_a, act_b, edge_a, edge_b;
  logic split, run_a, inc_a, inc_a_high, run_b, inc_b;
  logic ovf_a, ovf_a_high, ovf_b, set_tf1;
  logic [16:0] a_next, a_hnext, b_next;
  timer_mode_t mode_a, mode_b;
  prescale_t sca;
  logic [7:0] rd_byte;
  logic rd_hit;

  // ---------------- AXI4-Lite slave
  assign s_axi_awready_o = ~aw_full_q;
  assign s_axi_wready_o = ~w_full_q;
  assign s_axi_arready_o = ~rvalid_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rresp_o = rresp_q;
  assign s_axi_rdata_o = rdata_q;
  assign do_write = aw_full_q & w_full_q & ~bvalid_q;
  assign wr_hit = hit(aw_addr_q, IDX_RUN_FLAGS) | hit(aw_addr_q, IDX_MODE) |
                  hit(aw_addr_q, IDX_A_LOW) | hit(aw_addr_q, IDX_B_LOW) |
                  hit(aw_addr_q, IDX_A_HIGH) | hit(aw_addr_q, IDX_B_HIGH) |
                  hit(aw_addr_q, IDX_CLK_CTRL) | hit(aw_addr_q, IDX_IRQ_CFG);

  function automatic logic wr_to(input logic [7:0] idx);
    return do_write & w_strb_q & hit(aw_addr_q, idx);
  endfunction

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= RESET_BYTE;
      w_strb_q <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && !aw_full_q) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_i;
      end else if (do_write) begin
        aw_full_q <= 1'b0;
      end
      if (s_axi_wvalid_i && !w_full_q) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata_i[BYTE_W-1:0];
        w_strb_q <= s_axi_wstrb_i[0];
      end else if (do_write) begin
        w_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    if (hit(s_axi_araddr_i, IDX_RUN_FLAGS)) rd_byte = run_flags_q;
    else if (hit(s_axi_araddr_i, IDX_MODE)) rd_byte = mode_q;
    else if (hit(s_axi_araddr_i, IDX_A_LOW)) rd_byte = a_low_q;
    else if (hit(s_axi_araddr_i, IDX_B_LOW)) rd_byte = b_low_q;
    else if (hit(s_axi_araddr_i, IDX_A_HIGH)) rd_byte = a_high_q;
    else if (hit(s_axi_araddr_i, IDX_B_HIGH)) rd_byte = b_high_q;
    else if (hit(s_axi_araddr_i, IDX_CLK_CTRL)) rd_byte = clk_ctrl_q;
    else if (hit(s_axi_araddr_i, IDX_IRQ_CFG)) rd_byte = irq_cfg_q;
    else begin
      rd_byte = RESET_BYTE;
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid_i && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= DATA_W'(rd_byte);
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------- configuration registers
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mode_q <= RESET_BYTE;
      clk_ctrl_q <= RESET_BYTE;
      irq_cfg_q <= RESET_BYTE;
    end else begin
      if (wr_to(IDX_MODE)) mode_q <= w_data_q;
      if (wr_to(IDX_CLK_CTRL)) clk_ctrl_q <= w_data_q & CLK_CTRL_MASK;
      if (wr_to(IDX_IRQ_CFG)) irq_cfg_q <= w_data_q & IRQ_CFG_MASK;
    end
  end

  // ---------------- prescaler shared by both timers
  assign sca = prescale_t'(clk_ctrl_q[C_SCA +: 2]);
  always_comb begin
    case (sca)
      PRE_DIV12: pre_limit = PRE_W'(DIV12 - 1);
      PRE_DIV4: pre_limit = PRE_W'(DIV4 - 1);
      PRE_DIV48: pre_limit = PRE_W'(DIV48 - 1);
      PRE_EXT8: pre_limit = PRE_W'(DIV_EXT - 1);
      default: pre_limit = PRE_W'(DIV12 - 1);
    endcase
  end
  assign pre_step = (sca == PRE_EXT8) ? sync_if.rise[PIN_EXTCLK] : 1'b1;
  assign pre_tick = pre_step & (pre_cnt_q >= pre_limit);

  // >= lets a divider change mid-count wrap at once instead of running to 63
  always_ff @(posedge clock_i) begin
    if (srst_i) pre_cnt_q <= '0;
    else if (pre_tick) pre_cnt_q <= '0;
    else if (pre_step) pre_cnt_q <= pre_cnt_q + PRE_W'(1);
  end

  // ---------------- enables and increment sources
  assign tick_a = clk_ctrl_q[C_T0_SYS] | pre_tick;
  assign tick_b = clk_ctrl_q[C_T1_SYS] | pre_tick;
  assign act_a = irq_cfg_q[P_A_POL] ? sync_if.level[PIN_EXT_IRQ_A_INPUT] : ~sync_if.level[PIN_EXT_IRQ_A_INPUT];
  assign act_b = irq_cfg_q[P_B_POL] ? sync_if.level[PIN_EXT_IRQ_B_INPUT] : ~sync_if.level[PIN_EXT_IRQ_B_INPUT];
  assign edge_a = irq_cfg_q[P_A_POL] ? sync_if.rise[PIN_EXT_IRQ_A_INPUT] : sync_if.fall[PIN_EXT_IRQ_A_INPUT];
  assign edge_b = irq_cfg_q[P_B_POL] ? sync_if.rise[PIN_EXT_IRQ_B_INPUT] : sync_if.fall[PIN_EXT_IRQ_B_INPUT];
  assign mode_a = timer_mode_t'(mode_q[M_A_MODE +: MODE_W]);
  assign mode_b = timer_mode_t'(mode_q[M_B_MODE +: MODE_W]);
  assign split = (mode_a == MODE_SPLIT);
  assign run_a = run_flags_q[B_TR0] & (~mode_q[M_TIMER_A_GATE] | act_a);
  assign inc_a = run_a & (mode_q[M_CT0] ? sync_if.fall[PIN_T0] : tick_a);
  assign inc_a_high = split & run_flags_q[B_TR1] & tick_a;
  assign run_b = run_flags_q[B_TR1] & (~mode_q[M_TIMER_B_GATE] | act_b);
  // in split mode timer B is run by its mode field only and never sees its pin
  assign inc_b = (mode_b != MODE_SPLIT) &
                 (split ? tick_b : run_b & (mode_q[M_CT1] ? sync_if.fall[PIN_T1] : tick_b));

  assign a_next = count_step(mode_a, a_low_q, a_high_q);
  assign a_hnext = count_step(MODE_SPLIT, a_high_q, a_high_q);
  assign b_next = count_step(mode_b, b_low_q, b_high_q);
  assign ovf_a = inc_a & a_next[16];
  assign ovf_a_high = inc_a_high & a_hnext[16];
  assign ovf_b = inc_b & b_next[16];
  assign set_tf1 = split ? ovf_a_high : ovf_b;

  // ---------------- count registers; a software write wins over an increment
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      a_low_q <= RESET_BYTE;
      a_high_q <= RESET_BYTE;
    end else begin
      if (wr_to(IDX_A_LOW)) a_low_q <= w_data_q;
      else if (inc_a) a_low_q <= a_next[7:0];
      if (wr_to(IDX_A_HIGH)) a_high_q <= w_data_q;
      else if (inc_a_high) a_high_q <= a_hnext[7:0];
      else if (inc_a && !split) a_high_q <= a_next[15:8];
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      b_low_q <= RESET_BYTE;
      b_high_q <= RESET_BYTE;
      b_pulse_q <= 1'b0;
    end else begin
      if (wr_to(IDX_B_LOW)) b_low_q <= w_data_q;
      else if (inc_b) b_low_q <= b_next[7:0];
      if (wr_to(IDX_B_HIGH)) b_high_q <= w_data_q;
      else if (inc_b) b_high_q <= b_next[15:8];
      b_pulse_q <= ovf_b;
    end
  end

  // ---------------- run and flag register: hardware set beats any clear
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      run_flags_q <= RESET_BYTE;
    end else begin
      if (wr_to(IDX_RUN_FLAGS)) run_flags_q <= w_data_q;
      if (timer_a_vector_ack_i) run_flags_q[B_TF0] <= 1'b0;
      if (timer_b_vector_ack_i) run_flags_q[B_TF1] <= 1'b0;
      if (ext_irq_a_vector_ack_i && run_flags_q[B_IT0]) run_flags_q[B_IE0] <= 1'b0;
      if (ext_irq_b_vector_ack_i && run_flags_q[B_IT1]) run_flags_q[B_IE1] <= 1'b0;
      if (ovf_a) run_flags_q[B_TF0] <= 1'b1;
      if (set_tf1) run_flags_q[B_TF1] <= 1'b1;
      if (run_flags_q[B_IT0] ? edge_a : act_a) run_flags_q[B_IE0] <= 1'b1;
      if (run_flags_q[B_IT1] ? edge_b : act_b) run_flags_q[B_IE1] <= 1'b1;
    end
  end

  assign timer_a_overflow_flag_o = run_flags_q[B_TF0];
  assign timer_b_overflow_flag_o = run_flags_q[B_TF1];
  assign ext_irq_a_flag_o = run_flags_q[B_IE0];
  assign ext_irq_b_flag_o = run_flags_q[B_IE1];
  assign timer_b_overflow_pulse_o = b_pulse_q;

  // ---------------- assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  property p_tf0_set;
    ovf_a |=> run_flags_q[B_TF0];
  endproperty
  a_tf0_set: assert property (p_tf0_set) else $error("overflow did not set flag A");

  property p_split_high_sets_tf1;
    split && run_flags_q[B_TR1] && tick_a && a_high_q == 8'hff |=>
      run_flags_q[B_TF1] && a_high_q == 8'h00;
  endproperty
  a_split_high_sets_tf1: assert property (p_split_high_sets_tf1)
    else $error("split high byte overflow missed flag B");

  property p_b_no_flag_in_split;
    split && ovf_b && !ovf_a_high && !run_flags_q[B_TF1] && !do_write |=> !run_flags_q[B_TF1];
  endproperty
  a_b_no_flag_in_split: assert property (p_b_no_flag_in_split)
    else $error("timer B set its flag in split mode");

  property p_pulse_in_split;
    split && inc_b && b_next[16] |=> timer_b_overflow_pulse_o ##1
      (!timer_b_overflow_pulse_o || $past(ovf_b));
  endproperty
  a_pulse_in_split: assert property (p_pulse_in_split)
    else $error("timer B overflow pulse missing");

  property p_b_mode3_stopped;
    mode_b == MODE_SPLIT && !do_write |=> $stable(b_low_q) && $stable(b_high_q);
  endproperty
  a_b_mode3_stopped: assert property (p_b_mode3_stopped)
    else $error("timer B counted in mode 3");

  property p_reload;
    mode_a == MODE_RELOAD8 && ovf_a && !do_write |=> a_low_q == $past(a_high_q) && $stable(a_high_q);
  endproperty
  a_reload: assert property (p_reload) else $error("reload value not applied");

  property p_gate_holds;
    mode_q[M_TIMER_A_GATE] && !act_a && !do_write |=> $stable(a_low_q);
  endproperty
  a_gate_holds: assert property (p_gate_holds) else $error("gated timer A counted");

  property p_stopped_holds;
    !run_flags_q[B_TR0] && !do_write |=> $stable(a_low_q);
  endproperty
  a_stopped_holds: assert property (p_stopped_holds) else $error("stopped timer A counted");

  property p_split_high_needs_run;
    split && !run_flags_q[B_TR1] && !do_write |=> $stable(a_high_q);
  endproperty
  a_split_high_needs_run: assert property (p_split_high_needs_run)
    else $error("split high byte counted without run");

  property p_edge_ack_clears;
    ext_irq_a_vector_ack_i && run_flags_q[B_IT0] && !edge_a && !do_write |=> !run_flags_q[B_IE0];
  endproperty
  a_edge_ack_clears: assert property (p_edge_ack_clears)
    else $error("edge flag A not cleared on vector");

  property p_write_answer;
    do_write |=> bvalid_q && !aw_full_q && !w_full_q;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write not answered");

  c_split_tf1: cover property (split ##1 $rose(run_flags_q[B_TF1]));
  c_reload: cover property (mode_a == MODE_RELOAD8 && ovf_a);
  c_edge_irq: cover property (run_flags_q[B_IT0] && edge_a ##1 run_flags_q[B_IE0]);
endmodule // dual_timer_split_mode_control

// ==== hw/pin_sampler.sv ====
// three-stage pin synchroniser with agreement filter and edge pulses
module pin_sampler #(
  parameter int unsigned N = 5
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [N-1:0] pins_i,
  pin_sync_if.sampler sync_o
);
  import dual_timer_pkg::*;
  logic [N-1:0] meta_q, s2_q, s3_q, level_q, fall_q, rise_q, agree;
  logic [2:0] fill_q;

  always_ff @(posedge clock_i) begin
    // start at the idle high level of the active-low inputs, so no false
    // active level reaches a level-triggered flag while the chain fills
    if (srst_i) begin
      meta_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      meta_q <= pins_i;
      s2_q <= meta_q;
      s3_q <= s2_q;
    end
  end

  // edges are held off until the chain holds real pin samples
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      fill_q <= 3'h0;
    end else if (fill_q != SYNC_FILL) begin
      fill_q <= fill_q + 3'h1;
    end
  end

  assign agree = ~(s2_q ^ s3_q);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      level_q <= '1;
      fall_q <= '0;
      rise_q <= '0;
    end else begin
      level_q <= (agree & s3_q) | (~agree & level_q);
      fall_q <= (fill_q == SYNC_FILL) ? (agree & level_q & ~s3_q) : '0;
      rise_q <= (fill_q == SYNC_FILL) ? (agree & ~level_q & s3_q) : '0;
    end
  end

  assign sync_o.level = level_q;
  assign sync_o.fall = fall_q;
  assign sync_o.rise = rise_q;
endmodule // pin_sampler

// ==== hw/pin_sync_if.sv ====
// synchronised pin levels and edge pulses from the sampler to the timer logic
interface pin_sync_if #(parameter int unsigned N = 5);
  logic [N-1:0] level;
  logic [N-1:0] fall;
  logic [N-1:0] rise;
  modport sampler (output level, output fall, output rise);
  modport user (input level, input fall, input rise);
endinterface
